// ===== audio_amp_power_control.sv
/*
  apb register slave and decode of the amplifier and analog power controls.
  assumes an apb3 master on pclk; audio_reset_n comes from outside, asynchronous.
*/
// Decided for this implementation: the APB register port.
module audio_amp_power_control
  import audio_amp_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // audio supply reset from outside
  input wire logic audio_reset_n,
  // amplifier controls
  output amp_mode_t amp_mode,
  output logic amp_power_level,
  output logic [3:0] amp_gain_code,
  output logic signed [5:0] amp_gain_db,
  // analog block controls
  output block_power_t block_power,
  output logic codec_reset_mask,
  output logic codec_filter_reset_n,
  output logic codec_reset_n
);

  typedef struct packed {
    regs_t r;
    logic [1:0] ares_sync;
    amp_mode_t mode;
    logic signed [5:0] gain_db;
    block_power_t blk;
  } state_t;

  state_t s_q, s_d;
  logic acc, wr, rd, hit;
  logic [7:0] index;

  // gain code to decibels
  function automatic logic signed [5:0] gain_of(input logic [3:0] code);
    if (code == gain_min_a || code == gain_min_b) begin
      return gain_floor_db;
    end
    return 6'(gain_top_db - gain_step_db * 6'(signed'({2'b00, code}) - 6'sd1));
  endfunction : gain_of

  // mode from the on and precharge bits
  function automatic amp_mode_t mode_of(input logic on, input logic pre);
    unique case ({on, pre})
      2'b01: return amp_precharging;
      2'b10: return amp_active;
      default: return amp_standby;
    endcase
  endfunction : mode_of

  assign acc = psel && penable;
  assign index = 8'(paddr[addr_w-1:2]);
  assign wr = acc && pwrite;
  assign rd = psel && !penable && !pwrite;
  always_comb begin
    unique case (index)
      idx_power, idx_dac_power, idx_precharge, idx_codec_reset, idx_amp_control, idx_status: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.ares_sync = {s_q.ares_sync[0], audio_reset_n};
    if (wr && hit) begin
      unique case (index)
        idx_power: s_d.r.power = pwdata[7:0];
        idx_dac_power: s_d.r.dac_power = pwdata[7:0] & dac_power_mask;
        idx_precharge: s_d.r.precharge = pwdata[7:0];
        idx_codec_reset: s_d.r.codec_reset = pwdata[7:0] & codec_reset_mask_w;
        idx_amp_control: s_d.r.amp_control = pwdata[7:0] & amp_ctrl_mask;
        default: s_d.r = s_q.r;
      endcase
    end
    // audio reset held low keeps the analog registers at reset
    if (!s_q.ares_sync[1]) begin
      s_d.r.power = rst_byte;
      s_d.r.dac_power = rst_byte;
      s_d.r.precharge = rst_byte;
      s_d.r.codec_reset = rst_byte;
      s_d.r.amp_control = rst_byte;
    end
    // read data captured in the setup cycle
    if (rd) begin
      unique case (index)
        idx_power: s_d.r.prdata = {24'h0000_00, s_q.r.power};
        idx_dac_power: s_d.r.prdata = {24'h0000_00, s_q.r.dac_power};
        idx_precharge: s_d.r.prdata = {24'h0000_00, s_q.r.precharge};
        idx_codec_reset: s_d.r.prdata = {24'h0000_00, s_q.r.codec_reset};
        idx_amp_control: s_d.r.prdata = {24'h0000_00, s_q.r.amp_control};
        idx_status: s_d.r.prdata = {14'h0000, s_q.mode, 1'b0, s_q.blk.powered, s_q.blk.dac_on,
                                    s_q.ares_sync[1], 5'h00};
        default: s_d.r.prdata = 32'h0000_0000;
      endcase
    end
    s_d.mode = mode_of(s_q.r.amp_control[amp_on_bit], s_q.r.amp_control[amp_prech_bit]);
    s_d.gain_db = gain_of(s_q.r.amp_control[3:0]);
    // master in precharge register bit 0, others in power register bits 1..6
    s_d.blk.powered = {s_q.r.power[6:1], s_q.r.precharge[master_power_bit]};
    // fast charge runs only while both bits are high
    s_d.blk.charging = s_d.blk.powered & {s_q.r.precharge[7:2], s_q.r.precharge[master_fastcharge_bit]};
    s_d.blk.dac_on = s_q.r.dac_power[1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign prdata = s_q.r.prdata;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign amp_mode = s_q.mode;
  assign amp_power_level = s_q.r.amp_control[amp_lp_bit];
  assign amp_gain_code = s_q.r.amp_control[3:0];
  assign amp_gain_db = s_q.gain_db;
  assign block_power = s_q.blk;
  assign codec_reset_mask = s_q.r.codec_reset[rst_mask_bit];
  assign codec_filter_reset_n = s_q.r.codec_reset[rst_filt_bit];
  assign codec_reset_n = s_q.r.codec_reset[rst_codec_bit];

  chk_forbidden_standby: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.r.amp_control[6:5] == 2'b11) |=> (amp_mode == amp_standby))
    else $error("forbidden amp mode not in standby");
  chk_active_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.r.amp_control[6:5] == 2'b10) |=> (amp_mode == amp_active))
    else $error("amp not active");
  chk_prech_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.r.amp_control[6:5] == 2'b01) |=> (amp_mode == amp_precharging))
    else $error("amp not precharging");
  chk_gain_floor: assert property (@(posedge pclk) disable iff (!presetn)
    (amp_gain_code == 4'hF || amp_gain_code == 4'h0) |=> ($past(amp_gain_code) != amp_gain_code ||
    amp_gain_db == -6'sd22))
    else $error("gain floor wrong");
  chk_gain_top: assert property (@(posedge pclk) disable iff (!presetn)
    (amp_gain_code == 4'h1) ##1 (amp_gain_code == 4'h1) |-> (amp_gain_db == 6'sd20))
    else $error("top gain wrong");
  chk_amp_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_amp_control && s_q.ares_sync[1]) |=> (s_q.r.amp_control == ($past(pwdata[7:0]) & 8'h7F)))
    else $error("amp control write lost");
  chk_charge_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_q.r.precharge[0]) |=> (!block_power.charging[0] && !block_power.powered[0]))
    else $error("master charging while off");
  chk_codec_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_codec_reset && s_q.ares_sync[1]) |=> (codec_reset_n == $past(pwdata[0]) &&
    codec_reset_mask == $past(pwdata[2])))
    else $error("codec reset write lost");
  chk_power_down: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_power && s_q.ares_sync[1] && !pwdata[6]) |=> ##1 !block_power.powered[6])
    else $error("driver not powered down");

  // register writes reach the decoded outputs
  chk_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_amp_control && s_q.ares_sync[1]) |=> (amp_power_level == $past(pwdata[amp_lp_bit])))
    else $error("power level write lost");
  chk_gain_step: assert property (@(posedge pclk) disable iff (!presetn)
    (amp_gain_code != gain_min_a && amp_gain_code != gain_min_b) ##1 $stable(amp_gain_code) |->
    (amp_gain_db == 6'(6'sd23 - 6'sd3 * signed'({2'b00, amp_gain_code}))))
    else $error("gain step wrong");
  chk_dac_power: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_dac_power && s_q.ares_sync[1]) |=> ##1 (block_power.dac_on == $past(pwdata[1:0], 2)))
    else $error("dac power write lost");
  chk_block_power: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_power && s_q.ares_sync[1]) |=> ##1
    (block_power.powered[6:1] == $past(pwdata[6:1], 2)))
    else $error("block power write lost");
  chk_fastcharge_map: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_precharge && s_q.ares_sync[1]) |=> ##1
    (block_power.charging[6:1] == ($past(pwdata[7:2], 2) & block_power.powered[6:1])))
    else $error("fastcharge map wrong");

  // master fast charge follows power and fastcharge together; filter reset follows its write
  chk_master_charge: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.r.precharge[1:0] == 2'b11) |=> block_power.charging[0])
    else $error("master not charging");
  chk_codec_filter: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && index == idx_codec_reset && s_q.ares_sync[1]) |=> (codec_filter_reset_n == $past(pwdata[rst_filt_bit])))
    else $error("filter reset write lost");

  // audio reset held low keeps the controls at reset
  chk_audio_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_q.ares_sync[1]) |=> (s_q.r.amp_control == rst_byte && !codec_reset_n && !codec_reset_mask))
    else $error("controls not held in audio reset");

endmodule : audio_amp_power_control

// ===== audio_amp_pkg.sv
/*
  constants, types and register map for the audio amplifier power control block.
  assumes an apb master on pclk; control registers hold 8-bit data in the low bits of a 32-bit word, status uses bits 5..17.
*/
// Behaviour
// - gain code 0 and 15 give -22 dB; codes 1..14 step from +20 dB down by 3 dB
// - on and precharge bits pick stand-by, input precharge or active; both set is forbidden
// - power level bit 0 selects low power, 1 selects high power
// - amplifier control register resets to zero; bit 7 unused, reads zero
// - block fast charges while its fastcharge and power bits are both high
// - clearing a power bit powers the block down; reuse needs the full sequence
// - independent power and fastcharge pairs for seven blocks; master fastcharge is bit 1
// - dacs have power bits only; all blocks may precharge together
// - codec reset register: mask bit 2, filter reset_n bit 1, codec reset_n bit 0, reset zero
// - precharge register: bit 0 master power, bit 1 master fastcharge, bits 2..7 per block
package audio_amp_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] idx_power = 8'h00;
  localparam logic [7:0] idx_dac_power = 8'h01;
  localparam logic [7:0] idx_precharge = 8'h0C;
  localparam logic [7:0] idx_codec_reset = 8'h10;
  localparam logic [7:0] idx_amp_control = 8'h11;
  localparam logic [7:0] idx_status = 8'h20;
  localparam int addr_w = 10;
  // reset values
  localparam logic [7:0] rst_byte = 8'h00;
  // amp_control fields
  localparam int amp_on_bit = 6;
  localparam int amp_prech_bit = 5;
  localparam int amp_lp_bit = 4;
  localparam logic [7:0] amp_ctrl_mask = 8'h7F;
  localparam logic [3:0] gain_min_a = 4'h0;
  localparam logic [3:0] gain_min_b = 4'hF;
  localparam logic signed [5:0] gain_top_db = 6'sd20;
  localparam logic signed [5:0] gain_step_db = 6'sd3;
  localparam logic signed [5:0] gain_floor_db = -6'sd22;
  // codec reset fields
  localparam int rst_mask_bit = 2;
  localparam int rst_filt_bit = 1;
  localparam int rst_codec_bit = 0;
  localparam logic [7:0] codec_reset_mask_w = 8'h07;
  // power register fields (bits 0..1 dac power in register 01h)
  localparam int dac_left_bit = 0;
  localparam int dac_right_bit = 1;
  localparam logic [7:0] dac_power_mask = 8'h03;
  localparam int master_power_bit = 0;
  localparam int master_fastcharge_bit = 1;

  typedef enum logic [1:0] {
    amp_standby,
    amp_precharging,
    amp_active
  } amp_mode_t;

  // per block power and fastcharge: 0 master, 1 left line in, 2 right line in,
  // 3 left line out, 4 right line out, 5 aux input, 6 amp driver
  typedef struct packed {
    logic [6:0] powered;
    logic [6:0] charging;
    logic [1:0] dac_on;
  } block_power_t;

  typedef struct packed {
    logic [7:0] power;
    logic [7:0] dac_power;
    logic [7:0] precharge;
    logic [7:0] codec_reset;
    logic [7:0] amp_control;
    logic [31:0] prdata;
  } regs_t;
endpackage : audio_amp_pkg

// ===== tb_audio_amp_power_control.sv
/*
  self-checking bench for the audio amplifier power control block.
  assumes the block answers apb with pready and updates decoded outputs two cycles after a write.
*/
module tb_audio_amp_power_control
  import audio_amp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, audio_reset_n, pready, pslverr, err;
  logic [addr_w-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  amp_mode_t amp_mode;
  logic amp_power_level, codec_reset_mask, codec_filter_reset_n, codec_reset_n;
  logic [3:0] amp_gain_code;
  logic signed [5:0] amp_gain_db;
  block_power_t block_power;
  int fails, samples_checked, e;
  audio_amp_power_control audio_amp_power_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .audio_reset_n(audio_reset_n), .amp_mode(amp_mode), .amp_power_level(amp_power_level),
    .amp_gain_code(amp_gain_code), .amp_gain_db(amp_gain_db), .block_power(block_power),
    .codec_reset_mask(codec_reset_mask), .codec_filter_reset_n(codec_filter_reset_n),
    .codec_reset_n(codec_reset_n));
  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one apb transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // write and let decoded outputs settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
    repeat (3) @(posedge pclk);
  endtask : wr
  task automatic t_reset();
    apb(1'b0, idx_amp_control, 8'h00);
    chk("amp_control", rd, 32'h0000_0000);
    chk("mode", 32'(amp_mode), 32'(amp_standby));
    chk("codec", {29'h0, codec_reset_mask, codec_filter_reset_n, codec_reset_n}, 32'h0000_0000);
  endtask : t_reset
  task automatic t_gain();
    for (int c = 0; c < 16; c++) begin
      wr(idx_amp_control, {3'b000, c[0], c[3:0]});
      e = (c == 0 || c == 15) ? -22 : 20 - 3 * (c - 1);
      chk("gain_db", 32'(amp_gain_db), 32'(e));
      chk("gain_code", 32'(amp_gain_code), 32'(c));
      chk("power_level", 32'(amp_power_level), 32'(c % 2));
    end
  endtask : t_gain
  task automatic t_mode();
    amp_mode_t exp_mode [4] = '{amp_standby, amp_precharging, amp_active, amp_standby};
    for (int m = 0; m < 4; m++) begin
      wr(idx_amp_control, 8'(m << 5));
      chk("mode", 32'(amp_mode), 32'(exp_mode[m]));
    end
    wr(idx_amp_control, 8'hFF);
    apb(1'b0, idx_amp_control, 8'h00);
    chk("amp_control unused bit", rd, 32'h0000_007F);
  endtask : t_mode
  task automatic t_power();
    wr(idx_precharge, 8'hFF);
    wr(idx_power, 8'h7E);
    wr(idx_dac_power, 8'h03);
    chk("powered", 32'(block_power.powered), 32'h0000_007F);
    chk("charging", 32'(block_power.charging), 32'h0000_007F);
    chk("dac_on", 32'(block_power.dac_on), 32'h0000_0003);
    wr(idx_precharge, 8'h01);
    chk("charging off", 32'(block_power.charging), 32'h0000_0000);
    wr(idx_precharge, 8'h02);
    wr(idx_power, 8'h00);
    chk("powered off", 32'(block_power.powered), 32'h0000_0000);
    chk("no charge unpowered", 32'(block_power.charging), 32'h0000_0000);
  endtask : t_power
  task automatic t_codec();
    logic [7:0] seq [4] = '{8'h04, 8'h04, 8'h07, 8'h03};
    for (int i = 0; i < 4; i++) begin
      wr(idx_codec_reset, seq[i]);
      chk("codec", {29'h0, codec_reset_mask, codec_filter_reset_n, codec_reset_n}, 32'(seq[i]));
    end
    // settle wait shortened, the block keeps no timer
    repeat (10) @(posedge pclk);
    wr(idx_dac_power, 8'h03);
    chk("dacs on", 32'(block_power.dac_on), 32'h0000_0003);
    wr(idx_dac_power, 8'h00);
    chk("dacs off", 32'(block_power.dac_on), 32'h0000_0000);
  endtask : t_codec
  // amplifier click-free start and stop
  task automatic t_amp();
    wr(idx_amp_control, 8'h21);
    chk("precharge first", 32'(amp_mode), 32'(amp_precharging));
    wr(idx_amp_control, 8'h41);
    chk("then active", 32'(amp_mode), 32'(amp_active));
    chk("active gain", 32'(amp_gain_db), 32'(20));
    wr(idx_amp_control, 8'h40);
    chk("minimum gain", 32'(amp_gain_db), 32'(-22));
    wr(idx_amp_control, 8'h00);
    chk("amp off", 32'(amp_mode), 32'(amp_standby));
  endtask : t_amp
  // headset path power-on and power-off, dacs left off (the 0Ch dac write sets no dac bit), waits shortened
  task automatic t_headset();
    wr(idx_codec_reset, 8'h07);
    wr(idx_precharge, 8'hFF);
    wr(idx_power, 8'h30);
    repeat (20) @(posedge pclk);
    wr(idx_dac_power, 8'h0C);
    repeat (4) @(posedge pclk);
    wr(idx_power, 8'h3C);
    chk("headset powered", 32'(block_power.powered), 32'h0000_003D);
    chk("headset charging", 32'(block_power.charging), 32'h0000_003D);
    apb(1'b0, idx_status, 8'h00);
    chk("status", rd, 32'h0000_3D20);
    wr(idx_power, 8'h30);
    wr(idx_precharge, 8'h00);
    chk("master off", 32'(block_power.powered), 32'h0000_0030);
    chk("charge off", 32'(block_power.charging), 32'h0000_0000);
    repeat (4) @(posedge pclk);
    wr(idx_power, 8'h00);
    chk("all off", 32'(block_power.powered), 32'h0000_0000);
  endtask : t_headset
  task automatic t_refuse();
    wr(8'h05, 8'h55);
    chk("unmapped err", 32'(err), 32'h0000_0001);
    apb(1'b0, 8'h05, 8'h00);
    chk("unmapped read", rd, 32'h0000_0000);
    audio_reset_n <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(1'b0, idx_codec_reset, 8'h00);
    chk("audio reset clears", rd, 32'h0000_0000);
    wr(idx_amp_control, 8'h11);
    audio_reset_n <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, idx_amp_control, 8'h00);
    chk("write refused in audio reset", rd, 32'h0000_0000);
  endtask : t_refuse
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // supplies settle under reset, then the scenarios
  initial begin
    {presetn, psel, penable, pwrite, audio_reset_n} = 5'b00000;
    paddr = '0;
    pwdata = 32'h0000_0000;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    audio_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_gain();
    t_mode();
    t_power();
    t_codec();
    t_amp();
    t_headset();
    t_refuse();
    conclude();
  end
  // hang guard
  initial begin
    #20000;
    fails++;
    conclude();
  end
endmodule : tb_audio_amp_power_control
